// ### hw/ptr_regs.vh
// constants for the program memory table-read block
`ifndef PTR_REGS_VH
`define PTR_REGS_VH
`define PTR_ADDR_TBL_LOW   8'h07
`define PTR_ADDR_TBL_HIGH  8'h08
`define PTR_ADDR_TBL_PTRH  8'h1f
`define PTR_ADDR_IND       8'h00
`define PTR_ADDR_INDPTR    8'h01
`define PTR_ADDR_GP_BASE   8'h40
`define PTR_GP_DEPTH       160
`define PTR_VEC_TMR1       12'h00c
`define PTR_PAGE_LAST      4'hf
`define PTR_AXI_CTRL       8'h00
`define PTR_AXI_STAT       8'h04
`define PTR_AXI_THB        8'h08
`define PTR_AXI_TLOW       8'h0c
`define PTR_AXI_THIGH      8'h10
`define PTR_AXI_IPTR       8'h14
`define PTR_AXI_DADDR      8'h18
`define PTR_AXI_DDATA      8'h1c
`define PTR_AXI_VEC        8'h20
`define PTR_CTRL_HPEN      0
`define PTR_CTRL_IMPL_LSB  1
`define PTR_RESP_OKAY      2'b00
`define PTR_RESP_SLVERR    2'b10
`endif

// ### hw/ptr_dmem.v
// general purpose data memory with bit set and clear
`timescale 1ns/1ps
module ptr_dmem (
  input  wire       i_ref_clk,
  input  wire [7:0] i_addr,
  input  wire       i_we,
  input  wire [7:0] i_wdata,
  input  wire       i_bset,
  input  wire       i_bclr,
  input  wire [2:0] i_bit,
  output wire [7:0] o_rdata
);
  reg  [7:0] mem [0:159];
  wire [7:0] rd_w;
  wire [7:0] mask_w;

  // asynchronous read of the current word
  assign rd_w    = (i_addr < 8'd160) ? mem[i_addr] : 8'h00;
  assign mask_w  = 8'h01 << i_bit;
  assign o_rdata = rd_w;

  // word write or read-modify-write of one bit
  always @(posedge i_ref_clk) begin
    if (i_addr < 8'd160) begin
      if (i_we)
        mem[i_addr] <= i_wdata;
      else if (i_bset)
        mem[i_addr] <= rd_w | mask_w;
      else if (i_bclr)
        mem[i_addr] <= rd_w & ~mask_w;
    end
  end
endmodule // ptr_dmem

// ### hw/ptr_top.v
// table-read path: address forming, two-cycle sequencing, pointer registers, data memory
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "ptr_regs.vh"
module ptr_top (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  // axi4-lite slave
  input  wire [31:0] i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [31:0] i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  // core side
  input  wire [11:0] i_pc,
  input  wire        i_tab_cur,
  input  wire        i_tab_last,
  input  wire [7:0]  i_tab_dst,
  input  wire        i_tmr1_ovf,
  input  wire        i_tmr1_en,
  input  wire        i_stack_full,
  output reg         o_vec_take,
  output reg  [11:0] o_vec_addr,
  output reg         o_busy,
  // program memory port
  output reg  [11:0] o_pm_addr,
  output reg         o_pm_tab,
  input  wire [15:0] i_pm_data
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_XFER  = 3'b100;

  reg  [2:0]  state_r;
  reg  [7:0]  tbl_low_r;
  reg  [7:0]  tbl_ptrh_r;
  reg  [7:0]  tbl_high_r;
  reg  [7:0]  ind_ptr_r;
  reg         hpen_r;
  reg  [7:0]  impl_mask_r;
  reg  [11:0] tab_addr_r;
  reg  [7:0]  dst_r;
  reg  [7:0]  sw_daddr_r;
  reg  [7:0]  cnt_r;
  reg         aw_hold_r;
  reg  [31:0] aw_addr_r;
  reg         w_hold_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg  [11:0] tab_addr_nxt;
  reg  [7:0]  rd_word;
  reg  [7:0]  dm_addr;
  reg         dm_we;
  reg  [7:0]  dm_wdata;
  wire [7:0]  dm_rdata;
  wire        wr_go;

  // table address forming
  always @* begin
    if (i_tab_last)
      tab_addr_nxt = {`PTR_PAGE_LAST, tbl_low_r};
    else if (hpen_r)
      tab_addr_nxt = {tbl_ptrh_r[3:0], tbl_low_r};
    else
      tab_addr_nxt = {i_pc[11:8], tbl_low_r};
  end

  // two-cycle table instruction sequencer
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r    <= ST_IDLE;
      tab_addr_r <= 12'h000;
      dst_r      <= 8'h00;
      tbl_high_r <= 8'h00;
      cnt_r      <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (i_tab_cur || i_tab_last) begin
            tab_addr_r <= tab_addr_nxt;
            dst_r      <= i_tab_dst;
            state_r    <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_r <= ST_XFER;
        end
        ST_XFER: begin
          tbl_high_r <= i_pm_data[15:8] & impl_mask_r;
          cnt_r      <= cnt_r + 8'h01;
          state_r    <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // program port: table address while a read owns it, else the fetch address
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pm_addr <= 12'h000;
      o_pm_tab  <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      o_pm_tab  <= (state_r == ST_IDLE) && (i_tab_cur || i_tab_last);
      o_pm_addr <= ((state_r == ST_IDLE) && (i_tab_cur || i_tab_last)) ?
                   tab_addr_nxt : i_pc;
      o_busy    <= (state_r == ST_IDLE) && (i_tab_cur || i_tab_last);
    end
  end

  // timer 1 vector request
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vec_take <= 1'b0;
      o_vec_addr <= 12'h000;
    end else begin
      o_vec_take <= i_tmr1_ovf && i_tmr1_en && !i_stack_full;
      o_vec_addr <= `PTR_VEC_TMR1;
    end
  end

  // axi4-lite write channel capture
  assign o_awready = !aw_hold_r && !o_bvalid;
  assign o_wready  = !w_hold_r && !o_bvalid;
  assign wr_go     = aw_hold_r && w_hold_r && !o_bvalid && (state_r != ST_XFER);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // register writes and write response
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tbl_low_r   <= 8'h00;
      tbl_ptrh_r  <= 8'h00;
      ind_ptr_r   <= 8'h00;
      hpen_r      <= 1'b0;
      impl_mask_r <= 8'hff;
      sw_daddr_r  <= 8'h00;
      o_bvalid    <= 1'b0;
      o_bresp     <= `PTR_RESP_OKAY;
    end else begin
      if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= `PTR_RESP_OKAY;
        case (aw_addr_r[7:0])
          `PTR_AXI_CTRL: begin
            if (w_strb_r[0]) begin
              hpen_r <= w_data_r[`PTR_CTRL_HPEN];
            end
            if (w_strb_r[1]) begin
              impl_mask_r <= w_data_r[15:8];
            end
          end
          `PTR_AXI_TLOW:  if (w_strb_r[0]) tbl_low_r  <= w_data_r[7:0];
          `PTR_AXI_THIGH: if (w_strb_r[0]) tbl_ptrh_r <= w_data_r[7:0];
          `PTR_AXI_THB:   o_bresp <= `PTR_RESP_OKAY;
          `PTR_AXI_STAT:  o_bresp <= `PTR_RESP_OKAY;
          `PTR_AXI_IPTR:  if (w_strb_r[0]) ind_ptr_r  <= w_data_r[7:0];
          `PTR_AXI_DADDR: if (w_strb_r[0]) sw_daddr_r <= w_data_r[7:0];
          `PTR_AXI_DDATA: o_bresp <= `PTR_RESP_OKAY;
          `PTR_AXI_VEC:   o_bresp <= `PTR_RESP_OKAY;
          default:        o_bresp <= `PTR_RESP_SLVERR;
        endcase
      end
    end
  end

  // data memory port: table low byte has priority, then software data writes
  always @* begin
    dm_addr  = sw_daddr_r;
    dm_we    = 1'b0;
    dm_wdata = w_data_r[7:0];
    if (state_r == ST_XFER) begin
      dm_addr  = dst_r;
      dm_we    = 1'b1;
      dm_wdata = i_pm_data[7:0];
    end else if (wr_go && aw_addr_r[7:0] == `PTR_AXI_DDATA && w_strb_r[0]) begin
      dm_we = 1'b1;
    end else if (!(aw_hold_r && w_hold_r) && sw_daddr_r == 8'h00) begin
      dm_addr = ind_ptr_r;
    end
  end

  ptr_dmem i_ptr_dmem (
    .i_ref_clk (i_ref_clk),
    .i_addr    (dm_addr),
    .i_we      (dm_we),
    .i_wdata   (dm_wdata),
    .i_bset    (wr_go && aw_addr_r[7:0] == `PTR_AXI_DDATA && w_strb_r[1]
                && w_data_r[8]),
    .i_bclr    (wr_go && aw_addr_r[7:0] == `PTR_AXI_DDATA && w_strb_r[1]
                && w_data_r[9]),
    .i_bit     (w_data_r[12:10]),
    .o_rdata   (dm_rdata)
  );

  // register reads
  always @* begin
    case (i_araddr[7:0])
      `PTR_AXI_CTRL:  rd_word = {7'h00, hpen_r};
      `PTR_AXI_STAT:  rd_word = {5'h00, state_r};
      `PTR_AXI_THB:   rd_word = tbl_high_r;
      `PTR_AXI_TLOW:  rd_word = tbl_low_r;
      `PTR_AXI_THIGH: rd_word = tbl_ptrh_r;
      `PTR_AXI_IPTR:  rd_word = ind_ptr_r;
      `PTR_AXI_DADDR: rd_word = sw_daddr_r;
      `PTR_AXI_DDATA: rd_word = dm_rdata;
      `PTR_AXI_VEC:   rd_word = cnt_r;
      default:        rd_word = 8'h00;
    endcase
  end

  assign o_arready = !o_rvalid;

  // read response
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= `PTR_RESP_OKAY;
    end else begin
      if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata  <= {24'h000000, rd_word};
        o_rresp  <= (i_araddr[7:0] > `PTR_AXI_VEC || i_araddr[1:0] != 2'b00) ?
                    `PTR_RESP_SLVERR : `PTR_RESP_OKAY;
      end
    end
  end
endmodule // ptr_top

// ### test/ptr_pm_model.sv
// program memory model answering the table and fetch port
`timescale 1ns/1ps
module ptr_pm_model (
  input  wire logic        i_ref_clk,
  input  wire logic [11:0] i_addr,
  output logic      [15:0] o_data
);
  // registered read: the word for the address shown in one cycle stands in the next
  // every word differs with its address; a wrong page shows only in the high byte, wrong bits 7:4 only in the low byte
  always @(posedge i_ref_clk) begin
    o_data <= {i_addr[3:0] ^ 4'h5, i_addr[11:8], i_addr[7:0] ^ 8'ha5};
  end
endmodule // ptr_pm_model

// ### test/ptr_top_properties.sv
// timing checks on the table-read block ports
`timescale 1ns/1ps
module ptr_top_properties (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic [11:0] i_pc,
  input wire logic        i_tab_cur,
  input wire logic        i_tab_last,
  input wire logic        i_tmr1_ovf,
  input wire logic        i_tmr1_en,
  input wire logic        i_stack_full,
  input wire logic        o_vec_take,
  input wire logic [11:0] o_vec_addr,
  input wire logic        o_busy,
  input wire logic [11:0] o_pm_addr,
  input wire logic        o_pm_tab
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // a start of either kind
  wire st = i_tab_cur | i_tab_last;
  // vector, sequencing and bus relations
  property p_vec; i_tmr1_ovf && i_tmr1_en && !i_stack_full |=> o_vec_take && o_vec_addr == 12'h00c; endproperty
  a_vec: assert property (p_vec) else $error("vector not taken");
  property p_novec; !(i_tmr1_ovf && i_tmr1_en && !i_stack_full) |=> !o_vec_take; endproperty
  a_novec: assert property (p_novec) else $error("vector taken without cause");
  property p_two; st && !o_busy && !$past(o_busy) |=> o_busy ##1 !o_busy; endproperty
  a_two: assert property (p_two) else $error("table read not two cycles");
  property p_tab; st && !o_busy && !$past(o_busy) |=> o_pm_tab; endproperty
  a_tab: assert property (p_tab) else $error("table address not served");
  property p_last; i_tab_last && !o_busy && !$past(o_busy) |=> o_pm_addr[11:8] == 4'hf; endproperty
  a_last: assert property (p_last) else $error("last page not forced");
  property p_fetch; $past(i_rst_n) && !o_pm_tab |-> o_pm_addr == $past(i_pc); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");
  property p_one; o_pm_tab |=> !o_pm_tab; endproperty
  a_one: assert property (p_one) else $error("fetch not resumed");
  property p_rd; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
endmodule // ptr_top_properties
bind ptr_top ptr_top_properties i_ptr_top_properties (.i_ref_clk, .i_rst_n, .i_arvalid,
  .o_arready, .o_rvalid, .o_bvalid, .i_bready, .o_bresp, .i_pc, .i_tab_cur, .i_tab_last,
  .i_tmr1_ovf, .i_tmr1_en, .i_stack_full, .o_vec_take, .o_vec_addr, .o_busy, .o_pm_addr,
  .o_pm_tab);

// ### test/test_program_memory_table_read.sv
// self-checking bench for the table-read block
`timescale 1ns/1ps
module test_program_memory_table_read;
  logic        i_ref_clk = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic        i_arvalid = 0, i_rready = 0, i_tab_cur = 0, i_tab_last = 0;
  logic        i_tmr1_ovf = 0, i_tmr1_en = 0, i_stack_full = 0;
  logic [31:0] i_awaddr = 0, i_wdata = 0, i_araddr = 0, d;
  logic [3:0]  i_wstrb = 0;
  logic [11:0] i_pc = 12'h3a5;
  logic [7:0]  i_tab_dst = 8'h42;
  logic [1:0]  r;
  wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_vec_take, o_busy, o_pm_tab;
  wire  [1:0]  o_bresp, o_rresp;
  wire  [31:0] o_rdata;
  wire  [11:0] o_vec_addr, o_pm_addr;
  wire  [15:0] i_pm_data;
  int          error_cnt = 0, n_tests = 0, cyc = 0;
  ptr_top i_ptr_top (.i_ref_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pc, .i_tab_cur, .i_tab_last,
    .i_tab_dst, .i_tmr1_ovf, .i_tmr1_en, .i_stack_full, .o_vec_take, .o_vec_addr, .o_busy,
    .o_pm_addr, .o_pm_tab, .i_pm_data);
  ptr_pm_model i_ptr_pm_model (.i_ref_clk, .i_addr(o_pm_addr), .o_data(i_pm_data));
  // clock and hang guard
  always #2.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  task results();
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // axi4-lite write, both channels offered together
  task wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge i_ref_clk);
    i_awaddr <= a; i_wdata <= v; i_wstrb <= s;
    i_awvalid <= 1; i_wvalid <= 1; i_bready <= 1;
    do begin
      @(posedge i_ref_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end while (o_bvalid !== 1'b1);
    i_bready <= 0; r = o_bresp;
  endtask
  // axi4-lite read
  task rd(input logic [31:0] a);
    @(posedge i_ref_clk);
    i_araddr <= a; i_arvalid <= 1; i_rready <= 1;
    do begin
      @(posedge i_ref_clk);
      if (o_arready) i_arvalid <= 0;
    end while (o_rvalid !== 1'b1);
    i_rready <= 0; d = o_rdata; r = o_rresp;
  endtask
  // pointers, unmapped offset, reset of the control and status
  task t_regs();
    rd(32'h0); chk("ctrl", d[15:0], 32'h0000);
    rd(32'h4); chk("stat", d[7:0], 32'h1);
    wr(32'hc, 32'h5c, 4'hf); wr(32'h10, 32'ha9, 4'hf);
    rd(32'hc); chk("tlow", d[7:0], 32'h5c);
    rd(32'h10); chk("thigh", d[7:0], 32'ha9);
    rd(32'h24); chk("unmapped", r, 32'h2);
    wr(32'h24, 32'h0, 4'hf); chk("unmapped_wr", r, 32'h2);
  endtask
  // one table read in a given mode, then both bytes and the read-only holder
  task t_tab(input logic hp, input logic lst, input logic [11:0] a, input logic [7:0] m);
    logic [15:0] w;
    w = {a[3:0] ^ 4'h5, a[11:8], a[7:0] ^ 8'ha5};
    wr(32'h0, {16'h0, m, 7'h0, hp}, 4'hf);
    @(posedge i_ref_clk); i_tab_cur <= !lst; i_tab_last <= lst;
    @(posedge i_ref_clk); i_tab_cur <= 0; i_tab_last <= 0;
    repeat (3) @(posedge i_ref_clk);
    rd(32'h8); chk("high", d[7:0], w[15:8] & m);
    wr(32'h8, 32'h0, 4'hf); chk("ro_resp", r, 32'h0);
    rd(32'h8); chk("high_ro", d[7:0], w[15:8] & m);
    wr(32'h18, 32'h42, 4'hf); rd(32'h1c); chk("low", d[7:0], w[7:0]);
  endtask
  // data memory word, bit set and clear, indirect access
  task t_mem();
    rd(32'h20); chk("count", d[7:0], 32'h4);
    wr(32'h18, 32'h41, 4'hf); wr(32'h1c, 32'h3c, 4'h1);
    wr(32'h1c, 32'h1d00, 4'h2); rd(32'h1c); chk("bset", d[7:0], 32'hbc);
    wr(32'h1c, 32'h0a00, 4'h2); rd(32'h1c); chk("bclr", d[7:0], 32'hb8);
    wr(32'h14, 32'h41, 4'hf); wr(32'h18, 32'h0, 4'hf);
    rd(32'h1c); chk("indirect", d[7:0], 32'hb8);
  endtask
  // timer 1 vector held off by a full stack, then taken
  task t_vec();
    @(posedge i_ref_clk); i_tmr1_ovf <= 1; i_tmr1_en <= 1; i_stack_full <= 1;
    @(posedge i_ref_clk); i_stack_full <= 0;
    @(posedge i_ref_clk); chk("vec_full", o_vec_take, 32'h0); i_tmr1_ovf <= 0;
    @(posedge i_ref_clk); chk("vec", {o_vec_take, o_vec_addr}, 32'h100c);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1;
    t_regs();
    t_tab(0, 0, 12'h35c, 8'hff);
    t_tab(1, 0, 12'h95c, 8'hff);
    t_tab(1, 1, 12'hf5c, 8'h0f);
    t_tab(0, 1, 12'hf5c, 8'hff);
    t_mem();
    t_vec();
    results();
  end
endmodule // test_program_memory_table_read
